// ### hw/acs_chain_seq.sv
/*
  Converter chain sequencer: register port, scan chain control,
  injected conversions, chain abort and DMA request.
  Assumes timer trigger, DMA acknowledge and sample data come from
  logic on the same clock; the sample is valid when a conversion ends.
*/
`timescale 1ns/1ps
module acs_chain_seq (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic timer_trig_i,
  input wire logic [9:0] adc_sample_i,
  input wire logic dma_ack_i,
  output logic [2:0] mux_sel_o,
  output logic dma_req_o
);

  typedef struct packed {
    acs_pkg::acs_state_e state;
    logic normal_chain_start;
    logic xtrig;
    logic abort_pend;
    logic abort_done;
    logic inj_pend;
    logic [acs_pkg::NCH-1:0] chain_mask;
    logic dma_en;
    logic dma_clear_select;
    logic [5:0] timing;
    logic [acs_pkg::CH_W-1:0] inj_ch;
    logic [acs_pkg::CH_W-1:0] ch;
    logic [acs_pkg::CH_W-1:0] mux_sel;
    logic [acs_pkg::NCH-1:0][acs_pkg::DATA_W-1:0] data;
    logic [acs_pkg::DATA_W-1:0] inj_data;
    logic dma_req;
    logic [31:0] rdata;
  } acs_seq_s;

  localparam acs_seq_s RESET_S = '{
    state: acs_pkg::ST_IDLE,
    timing: acs_pkg::TIM_RESET,
    default: '0
  };

  acs_seq_s q;
  acs_seq_s d;
  acs_conv_if cv ();

  acs_conv_timer u_tmr (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .cv(cv)
  );

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Lowest enabled channel at or above from; msb of the result is found
  function automatic logic [3:0] seek(input logic [7:0] mask, input logic [3:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = acs_pkg::NCH - 1; i >= 0; i--)
    begin
      if (mask[i] && (4'(i) >= from))
        r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  function automatic logic is_data(input logic [7:0] a);
    return a[7:5] == acs_pkg::OFF_DATA0[7:5];
  endfunction

  logic [3:0] first_w;
  logic [3:0] next_w;
  logic run_w;
  logic [1:0] cmp_w;
  logic data_rd_w;

  assign first_w = seek(q.chain_mask, 4'h0);
  assign next_w = seek(q.chain_mask, {1'b0, q.ch} + 4'h1);
  assign run_w = q.normal_chain_start && !q.xtrig; // R1
  assign data_rd_w = rd_i && is_data(addr_i);
  // Forbidden compare setting runs as the substitute one
  assign cmp_w = (q.timing[acs_pkg::TIM_CMP_LSB +: 2] == acs_pkg::CMP_FORBIDDEN) ?
                 acs_pkg::CMP_SUBST : q.timing[acs_pkg::TIM_CMP_LSB +: 2]; // R6

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    d = q;
    cv.start = 1'b0;
    cv.abort = 1'b0;
    cv.cycles = acs_pkg::CONV_BASE_CYCLES + 5'(q.timing[acs_pkg::TIM_SMP_LSB +: 4])
                + 5'(cmp_w);
    d.rdata = '0;

    unique case (q.state)
      acs_pkg::ST_IDLE:
      begin
        if (q.abort_pend)
        begin
          d.abort_pend = 1'b0;
          d.abort_done = 1'b1;
        end
        else if (q.inj_pend)
        begin
          cv.start = 1'b1; // R2
          d.inj_pend = 1'b0;
          d.mux_sel = q.inj_ch;
          d.state = acs_pkg::ST_INJ;
        end
        else if (run_w && first_w[3])
        begin
          cv.start = 1'b1; // R1
          d.ch = first_w[2:0];
          d.mux_sel = first_w[2:0];
          d.state = acs_pkg::ST_NORM;
        end
      end
      acs_pkg::ST_NORM:
      begin
        if (q.abort_pend)
        begin
          // Pointer restarts at the first channel, so no channel repeats
          cv.abort = 1'b1; // R3
          d.abort_pend = 1'b0;
          d.abort_done = 1'b1;
          d.state = acs_pkg::ST_IDLE;
        end
        else if (q.inj_pend)
        begin
          // Restart drops the conversion in flight, so the slot never sits idle
          cv.start = 1'b1; // R2
          d.inj_pend = 1'b0;
          d.mux_sel = q.inj_ch;
          d.state = acs_pkg::ST_INJ;
        end
        else if (cv.done)
        begin
          d.data[q.ch] = adc_sample_i;
          d.dma_req = q.dma_req | q.dma_en;
          if (next_w[3])
          begin
            cv.start = 1'b1;
            d.ch = next_w[2:0];
            d.mux_sel = next_w[2:0];
          end
          else if (run_w && first_w[3])
          begin
            cv.start = 1'b1; // R1
            d.ch = first_w[2:0];
            d.mux_sel = first_w[2:0];
          end
          else
            d.state = acs_pkg::ST_IDLE;
        end
      end
      acs_pkg::ST_INJ:
      begin
        if (cv.done)
        begin
          d.inj_data = adc_sample_i;
          if (run_w && first_w[3])
          begin
            cv.start = 1'b1; // R2
            d.ch = first_w[2:0];
            d.mux_sel = first_w[2:0];
            d.state = acs_pkg::ST_NORM;
          end
          else
            d.state = acs_pkg::ST_IDLE;
        end
      end
      default:
        d.state = acs_pkg::ST_IDLE;
    endcase

    // DMA clear: by data read under clear-select, else by acknowledge
    if (q.dma_clear_select ? data_rd_w : dma_ack_i)
      d.dma_req = 1'b0; // R5
    if (q.state == acs_pkg::ST_NORM && cv.done && !q.abort_pend && !q.inj_pend && q.dma_en)
      d.dma_req = 1'b1;

    if (wr_i)
    begin
      unique case (addr_i)
        acs_pkg::OFF_MAIN:
        begin
          d.normal_chain_start = wdata_i[acs_pkg::MAIN_NORMAL_CHAIN_START_BIT];
          d.xtrig = wdata_i[acs_pkg::MAIN_XTRIG_BIT];
          if (wdata_i[acs_pkg::MAIN_INJECTED_START_BIT])
            d.inj_pend = 1'b1;
          if (wdata_i[acs_pkg::MAIN_ABORT_BIT])
          begin
            d.abort_pend = 1'b1;
            d.abort_done = 1'b0;
          end
        end
        acs_pkg::OFF_CHAIN: d.chain_mask = wdata_i[acs_pkg::NCH-1:0];
        acs_pkg::OFF_DMA:
        begin
          d.dma_en = wdata_i[acs_pkg::DMA_EN_BIT];
          d.dma_clear_select = wdata_i[acs_pkg::DMA_CLR_SEL_BIT];
        end
        acs_pkg::OFF_TIMING: d.timing = wdata_i[5:0];
        acs_pkg::OFF_INJ_CH: d.inj_ch = wdata_i[acs_pkg::CH_W-1:0];
        default: ;
      endcase
    end
    if (timer_trig_i)
      d.inj_pend = 1'b1; // R2

    if (rd_i)
    begin
      if (is_data(addr_i))
        d.rdata = 32'(q.data[addr_i[4:2]]);
      else
      begin
        unique case (addr_i)
          acs_pkg::OFF_MAIN:
            d.rdata = 32'({q.xtrig, q.abort_pend, 1'b0, q.normal_chain_start});
          acs_pkg::OFF_CHAIN: d.rdata = 32'(q.chain_mask);
          acs_pkg::OFF_DMA: d.rdata = 32'({q.dma_clear_select, q.dma_en});
          acs_pkg::OFF_TIMING: d.rdata = 32'(q.timing);
          acs_pkg::OFF_STATUS:
            d.rdata = 32'({q.ch, 1'b0, q.abort_done, q.state == acs_pkg::ST_INJ,
                           q.state != acs_pkg::ST_IDLE});
          acs_pkg::OFF_INJ_CH: d.rdata = 32'(q.inj_ch);
          acs_pkg::OFF_INJ_DATA: d.rdata = 32'(q.inj_data);
          default: d.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q <= RESET_S;
    else
      q <= d;
  end

  assign rdata_o = q.rdata;
  assign mux_sel_o = q.mux_sel;
  assign dma_req_o = q.dma_req;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence inj_taken;
    q.state == acs_pkg::ST_NORM && q.inj_pend && !q.abort_pend;
  endsequence

  sequence inj_running;
    q.state == acs_pkg::ST_INJ && cv.done == 1'b0;
  endsequence

  scan_wraps_a: assert property ( // R1
    (q.state == acs_pkg::ST_NORM && cv.done && !q.abort_pend && !q.inj_pend
     && !next_w[3] && run_w && first_w[3])
    |=> (q.state == acs_pkg::ST_NORM && q.ch == $past(first_w[2:0])))
    else $error("scan chain did not restart");

  inj_enter_a: assert property ( // R2
    inj_taken |=> inj_running ##0 q.mux_sel == $past(q.inj_ch))
    else $error("injected conversion not entered");

  inj_resume_a: assert property ( // R2
    (q.state == acs_pkg::ST_INJ && cv.done && run_w && first_w[3])
    |=> (q.state == acs_pkg::ST_NORM && q.ch == $past(first_w[2:0])))
    else $error("scan not resumed after injected conversion");

  inj_ends_a: assert property ( // R2
    (q.state != acs_pkg::ST_INJ && q.inj_pend && !q.abort_pend)
    |=> ##[1:60] q.state != acs_pkg::ST_INJ)
    else $error("injected conversion stalled");

  abort_stop_a: assert property ( // R3
    (q.state == acs_pkg::ST_NORM && q.abort_pend)
    |=> (q.state == acs_pkg::ST_IDLE && q.abort_done && !q.abort_pend))
    else $error("chain abort not honoured");

  dma_hold_a: assert property ( // R5
    (q.dma_req && q.dma_clear_select && !data_rd_w) |=> q.dma_req)
    else $error("dma request dropped before data read");

  cmp_subst_a: assert property ( // R6
    cv.start |-> cv.cycles >= acs_pkg::CONV_BASE_CYCLES + 5'h01)
    else $error("conversion shorter than substitute compare timing");

endmodule

// ### hw/acs_pkg.sv
/*
  Constants, register map and state encoding for the converter chain
  sequencer. Assumes a single 100 MHz clock and an 8-bit byte address
  on the register port.
*/
// Operation
// R1 - Normal start outside cross-trigger mode scans the chain repeatedly.
// R2 - Software or timer channel 5 injected request runs, then scan restarts.
// R3 - Chain abort stops the scan; next scan converts each channel once in order.
// R4 - Software sets abort with start cleared, restarts only after abort completes.
// R5 - With clear-select set, DMA request holds until a data register is read.
// R6 - Compare timing 00 is forbidden; the converter behaves as 01.
package acs_pkg;

  localparam int NCH = 8;
  localparam int CH_W = 3;
  localparam int DATA_W = 10;
  localparam int ADDR_W = 8;
  localparam int CYC_W = 5;

  localparam logic [7:0] OFF_MAIN = 8'h00;
  localparam logic [7:0] OFF_CHAIN = 8'h04;
  localparam logic [7:0] OFF_DMA = 8'h08;
  localparam logic [7:0] OFF_TIMING = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_INJ_CH = 8'h14;
  localparam logic [7:0] OFF_INJ_DATA = 8'h18;
  localparam logic [7:0] OFF_DATA0 = 8'h20;

  localparam int MAIN_NORMAL_CHAIN_START_BIT = 0;
  localparam int MAIN_INJECTED_START_BIT = 1;
  localparam int MAIN_ABORT_BIT = 2;
  localparam int MAIN_XTRIG_BIT = 3;

  localparam int DMA_EN_BIT = 0;
  localparam int DMA_CLR_SEL_BIT = 1;

  localparam int TIM_CMP_LSB = 0;
  localparam int TIM_SMP_LSB = 2;
  localparam logic [1:0] CMP_FORBIDDEN = 2'h0;
  localparam logic [1:0] CMP_SUBST = 2'h1;
  localparam logic [5:0] TIM_RESET = 6'h05;

  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_INJ_BIT = 1;
  localparam int STAT_ABORT_DONE_BIT = 2;
  localparam int STAT_CH_LSB = 4;

  // Conversion time in clocks is this base plus sample and compare fields
  localparam logic [CYC_W-1:0] CONV_BASE_CYCLES = 5'h04;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_NORM = 3'h2,
    ST_INJ = 3'h4
  } acs_state_e;

endpackage

// ### hw/acs_conv_if.sv
/*
  Link between the sequencer and its conversion timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface acs_conv_if;
  logic start;
  logic abort;
  logic [acs_pkg::CYC_W-1:0] cycles;
  logic done;

  modport ctrl (output start, output abort, output cycles, input done);
  modport eng (input start, input abort, input cycles, output done);
endinterface

// ### hw/acs_conv_timer.sv
/*
  Conversion timer: counts one conversion and pulses done at its end.
  Assumes start and abort are never raised together.
*/
`timescale 1ns/1ps
module acs_conv_timer (
  input wire logic clock_i,
  input wire logic rst_n_i,
  acs_conv_if.eng cv
);

  typedef struct packed {
    logic busy;
    logic [acs_pkg::CYC_W-1:0] cnt;
    logic done;
  } acs_tmr_s;

  acs_tmr_s q;
  acs_tmr_s d;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    if (cv.abort)
    begin
      d.busy = 1'b0;
    end
    else if (cv.start)
    begin
      d.busy = 1'b1;
      d.cnt = cv.cycles;
    end
    else if (q.busy)
    begin
      if (q.cnt == 5'h01)
      begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
      d.cnt = q.cnt - 5'h01;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q <= '0;
    else
      q <= d;
  end

  assign cv.done = q.done;

endmodule

// ### sim/acs_far_side.sv
/*
  Far side model: converter input, timer channel trigger, DMA controller.
  Assumes the sequencer clock; the bench commands each trigger pulse.
*/
`timescale 1ns/1ps
module acs_far_side (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [2:0] mux_sel_i,
  input wire logic dma_req_i,
  input wire logic trig_cmd_i,
  input wire logic slow_i,
  output logic [9:0] sample_o,
  output logic trig_o,
  output logic ack_o
);
  logic [1:0] wait_q;

  // Result tied to the channel, so every stored word is traceable
  assign sample_o = {7'h2A, mux_sel_i};

  ////////////////////////////////////////////////////////////////////
  // Slow mode waits four cycles before each acknowledge
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      trig_o <= 1'b0;
      ack_o <= 1'b0;
      wait_q <= 2'h0;
    end
    else
    begin
      trig_o <= trig_cmd_i;
      ack_o <= dma_req_i && !ack_o && (!slow_i || wait_q == 2'h3);
      wait_q <= dma_req_i ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule

// ### sim/tb_top.sv
/*
  Testbench for the chain sequencer: register table, scan, injected,
  abort, DMA and timing cases. Assumes the far side model beside it.
*/
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} acs_row_s;
  logic clock_i, rst_n_i, wr, rd, trig, trig_cmd, slow, ack, req;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [9:0] smp;
  logic [2:0] mux, ch;
  int bad_count, n_tests;
  int dw [4];
  logic [31:0] seq [3] = '{32'h0, 32'h1, 32'h3};
  logic [31:0] tim [3] = '{32'h1, 32'h0, 32'h2};
  acs_row_s rows [7] = '{
    '{acs_pkg::OFF_CHAIN, 32'h000001FF, 32'h000000FF},
    '{acs_pkg::OFF_DMA, 32'hFFFFFFFE, 32'h00000002},
    '{acs_pkg::OFF_TIMING, 32'h00000006, 32'h00000006},
    '{acs_pkg::OFF_INJ_CH, 32'h0000000F, 32'h00000007},
    '{acs_pkg::OFF_MAIN, 32'h00000008, 32'h00000008},
    '{acs_pkg::OFF_STATUS, 32'h000000FF, 32'h00000000},
    '{8'h40, 32'h00000001, 32'h00000000}};

  acs_chain_seq dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .timer_trig_i(trig),
    .adc_sample_i(smp), .dma_ack_i(ack), .mux_sel_o(mux), .dma_req_o(req));
  acs_far_side far (.clock_i(clock_i), .rst_n_i(rst_n_i), .mux_sel_i(mux),
    .dma_req_i(req), .trig_cmd_i(trig_cmd), .slow_i(slow), .sample_o(smp),
    .trig_o(trig), .ack_o(ack));

  ////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Dwell counts cycles until the selected channel moves on
  task automatic next_ch(output logic [2:0] c, output int n);
    logic [2:0] c0;
    c0 = mux;
    n = 0;
    while (mux === c0 && n < 200)
    begin
      tick(1);
      n++;
    end
    c = mux;
  endtask

  task automatic wait_req();
    for (int i = 0; i < 100 && req !== 1'b1; i++)
      tick(1);
  endtask

  task automatic stop_test();
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  initial
  begin
    #100us;
    bad_count++;
    stop_test();
  end

  initial
  begin
    rst_n_i = 1'b0;
    addr = 8'h00;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
    trig_cmd = 1'b0;
    slow = 1'b0;
    tick(2);
    chk(rdata | {28'h0, req, mux}, 32'h0);
    rst_n_i <= 1'b1;
    rd_reg(acs_pkg::OFF_TIMING, v);
    chk(v, 32'h00000005);
    foreach (rows[i])
    begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, v);
      chk(v, rows[i].e);
    end
    wr_reg(acs_pkg::OFF_MAIN, 32'h00000009);
    tick(10);
    rd_reg(acs_pkg::OFF_STATUS, v);
    chk(v & 32'h1, 32'h0);
    wr_reg(acs_pkg::OFF_CHAIN, 32'h0000000B);
    wr_reg(acs_pkg::OFF_MAIN, 32'h00000001);
    for (int i = 0; i < 6; i++)
    begin
      next_ch(ch, dw[0]);
      chk({29'h0, ch}, seq[(i + 1) % 3]);
    end
    for (int i = 0; i < 4; i++)
    begin
      rd_reg(acs_pkg::OFF_DATA0 + 8'(4 * i), v);
      chk(v, i == 2 ? 32'h0 : 32'h150 + 32'(i));
    end
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(acs_pkg::OFF_TIMING, tim[i]);
      next_ch(ch, dw[3]);
      next_ch(ch, dw[i]);
    end
    chk(32'(dw[0]), 32'(dw[1]));
    chk(32'(dw[2]), 32'(dw[0] + 1));
    // Software request first, then the timer channel
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(acs_pkg::OFF_INJ_CH, 32'h5 + 32'(k));
      next_ch(ch, dw[3]);
      if (k == 0)
        wr_reg(acs_pkg::OFF_MAIN, 32'h00000003);
      else
      begin
        trig_cmd <= 1'b1;
        tick(1);
        trig_cmd <= 1'b0;
      end
      next_ch(ch, dw[3]);
      chk({29'h0, ch}, 32'h5 + 32'(k));
      rd_reg(acs_pkg::OFF_STATUS, v);
      chk(v & 32'h3, 32'h3);
      next_ch(ch, dw[3]);
      chk({29'h0, ch}, 32'h0);
      rd_reg(acs_pkg::OFF_INJ_DATA, v);
      chk(v, 32'h155 + 32'(k));
    end
    for (int i = 0; i < 3 && ch !== 3'h3; i++)
      next_ch(ch, dw[3]);
    wr_reg(acs_pkg::OFF_MAIN, 32'h00000004);
    tick(3);
    rd_reg(acs_pkg::OFF_STATUS, v);
    chk(v & 32'h5, 32'h4);
    wr_reg(acs_pkg::OFF_MAIN, 32'h00000001);
    for (int i = 0; i < 4; i++)
    begin
      next_ch(ch, dw[i]);
      chk({29'h0, ch}, seq[i % 3]);
    end
    chk(32'(dw[1]), 32'(dw[2]));
    wr_reg(acs_pkg::OFF_DMA, 32'h00000003);
    wait_req();
    wr_reg(acs_pkg::OFF_MAIN, 32'h00000004);
    tick(20);
    chk({31'h0, req}, 32'h1);
    rd_reg(acs_pkg::OFF_DATA0, v);
    tick(2);
    chk({31'h0, req}, 32'h0);
    slow <= 1'b1;
    wr_reg(acs_pkg::OFF_DMA, 32'h00000001);
    wr_reg(acs_pkg::OFF_MAIN, 32'h00000001);
    wait_req();
    wr_reg(acs_pkg::OFF_MAIN, 32'h00000004);
    tick(12);
    chk({31'h0, req}, 32'h0);
    stop_test();
  end
endmodule
